// >>> shared/flash_self_prog_defines.svh
// constants for the flash self-programming control block
`ifndef FLASH_SELF_PROG_DEFINES_SVH
`define FLASH_SELF_PROG_DEFINES_SVH

// ==========================================================
// register address and bit positions
`define SPCS_ADDR       6'h37
`define SPCS_RESET      8'h00
`define BIT_IRQ_EN      7
`define BIT_SEC_BUSY    6
`define BIT_SIG_RD      5
`define BIT_SEC_RE      4
`define BIT_LOCK_RD     3
`define BIT_PG_WRT      2
`define BIT_PG_ERS      1
`define BIT_STORE_EN    0

// ==========================================================
// accepted command patterns in the lower five bits
`define CMD_SEC_RE      5'h11
`define CMD_LOCK_RD     5'h09
`define CMD_PG_WRT      5'h05
`define CMD_PG_ERS      5'h03
`define CMD_STORE       5'h01

// ==========================================================
// arming windows in cpu cycles
`define SPM_WINDOW      3'h4
`define LPM_WINDOW      3'h3

// ==========================================================
// timing
`define CLK_PERIOD_NS   10
`define TICK_NS         1000
`define TICK_CYCLES     ((`TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_MIN_US     3700
`define PROG_MAX_US     4500
`define PROG_TICKS      ((`PROG_MIN_US * 1000 + `TICK_NS - 1) / `TICK_NS)

`endif

// >>> shared/flash_self_prog_pkg.sv
// types for the flash self-programming control block
package flash_self_prog_pkg;

    // instruction strobes from the cpu core
    typedef struct packed {
        logic        spm;
        logic        lpm;
        logic [15:0] z_ptr;
        logic [15:0] operand;
    } instr_req_t;

    // operation request to the flash array
    typedef struct packed {
        logic        erase;
        logic        write;
        logic        load;
        logic        clear;
        logic [15:0] z_ptr;
        logic [15:0] operand;
    } flash_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_BUSY
    } seq_state_t;

endpackage : flash_self_prog_pkg

// >>> core/flash_self_program_control.sv
// control and status logic for flash self-programming
`timescale 1ns/10ps
`include "flash_self_prog_defines.svh"

module flash_self_program_control #(
    parameter int PROG_TICKS = `PROG_TICKS
) (
    // clock and reset
    input  wire logic                            clk_i,
    input  wire logic                            rst_b_i,
    // io register port
    input  wire logic [5:0]                      io_addr_i,
    input  wire logic                            io_wr_i,
    input  wire logic [7:0]                      io_wdata_i,
    output logic      [7:0]                      io_rdata_o,
    // cpu instruction side
    input  wire flash_self_prog_pkg::instr_req_t instr_i,
    input  wire logic                            global_irq_i,
    input  wire logic                            eeprom_write_pending_i,
    output logic                                 cpu_halt_o,
    output logic                                 ready_irq_o,
    output logic                                 lpm_override_o,
    output logic      [7:0]                      lpm_data_o,
    // nonvolatile sources
    input  wire logic [7:0]                      lock_bits_i,
    input  wire logic [7:0]                      fuse_bits_i,
    input  wire logic [7:0]                      signature_i,
    // flash array side
    output flash_self_prog_pkg::flash_cmd_t      flash_cmd_o
);

    // ==========================================================
    // state
    flash_self_prog_pkg::seq_state_t state;
    logic [7:0]  ctrl;
    logic [2:0]  age;
    logic [6:0]  tick_div;
    logic        tick;
    logic [15:0] prog_cnt;
    logic        prog_done;
    logic        cmd_wr;
    logic        pat_ok;
    logic        spm_ok;
    logic        lpm_ok;
    logic        spm_go;

    // ==========================================================
    // decode
    assign cmd_wr = io_wr_i && (io_addr_i == `SPCS_ADDR);
    always_comb begin
        pat_ok = 1'b0;
        case (io_wdata_i[4:0])
            `CMD_SEC_RE,
            `CMD_LOCK_RD,
            `CMD_PG_WRT,
            `CMD_PG_ERS,
            `CMD_STORE: pat_ok = !eeprom_write_pending_i;
            default:    pat_ok = 1'b0;
        endcase
    end
    assign spm_ok = (state == flash_self_prog_pkg::ST_ARMED) && (age < `SPM_WINDOW);
    assign lpm_ok = (state == flash_self_prog_pkg::ST_ARMED) && (age < `LPM_WINDOW);
    assign spm_go = instr_i.spm && spm_ok && !ctrl[`BIT_SIG_RD];

    // ==========================================================
    // timing base from the calibrated clock
    assign tick = (tick_div == 7'(`TICK_CYCLES - 1));
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_div <= 7'h00;
        end else if (state != flash_self_prog_pkg::ST_BUSY || tick) begin
            tick_div <= 7'h00;
        end else begin
            tick_div <= tick_div + 7'h01;
        end
    end

    assign prog_done = tick && (prog_cnt == 16'(PROG_TICKS - 1));
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prog_cnt <= 16'h0000;
        end else if (state != flash_self_prog_pkg::ST_BUSY) begin
            prog_cnt <= 16'h0000;
        end else if (tick) begin
            prog_cnt <= prog_cnt + 16'h0001;
        end
    end

    // ==========================================================
    // sequencer
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= flash_self_prog_pkg::ST_IDLE;
        end else begin
            case (state)
                flash_self_prog_pkg::ST_IDLE: begin
                    if (cmd_wr && pat_ok) begin
                        state <= flash_self_prog_pkg::ST_ARMED;
                    end
                end
                flash_self_prog_pkg::ST_ARMED: begin
                    if (spm_go && (ctrl[`BIT_PG_WRT] || ctrl[`BIT_PG_ERS])) begin
                        state <= flash_self_prog_pkg::ST_BUSY;
                    end else if (spm_go || (instr_i.lpm && lpm_ok &&
                                 (ctrl[`BIT_LOCK_RD] || ctrl[`BIT_SIG_RD]))) begin
                        state <= flash_self_prog_pkg::ST_IDLE;
                    end else if (age == `SPM_WINDOW - 3'h1) begin
                        state <= flash_self_prog_pkg::ST_IDLE;
                    end
                end
                flash_self_prog_pkg::ST_BUSY: begin
                    if (prog_done) begin
                        state <= flash_self_prog_pkg::ST_IDLE;
                    end
                end
                default: state <= flash_self_prog_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            age <= 3'h0;
        end else if (cmd_wr && pat_ok && state == flash_self_prog_pkg::ST_IDLE) begin
            age <= 3'h0;
        end else if (state == flash_self_prog_pkg::ST_ARMED) begin
            age <= age + 3'h1;
        end
    end

    // ==========================================================
    // control register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl <= `SPCS_RESET;
        end else begin
            if (cmd_wr) begin
                ctrl[`BIT_IRQ_EN] <= io_wdata_i[`BIT_IRQ_EN];
            end
            if (cmd_wr && pat_ok && state == flash_self_prog_pkg::ST_IDLE) begin
                ctrl[5:0] <= {io_wdata_i[5] && io_wdata_i[4:0] == `CMD_STORE,
                              io_wdata_i[4:0]};
            end else if (state == flash_self_prog_pkg::ST_ARMED &&
                         (spm_go || (instr_i.lpm && lpm_ok &&
                          (ctrl[`BIT_LOCK_RD] || ctrl[`BIT_SIG_RD])) ||
                          age == `SPM_WINDOW - 3'h1)) begin
                if (!(spm_go && (ctrl[`BIT_PG_WRT] || ctrl[`BIT_PG_ERS]))) begin
                    ctrl[5:0] <= 6'h00;
                end
            end else if (state == flash_self_prog_pkg::ST_BUSY && prog_done) begin
                ctrl[5:0] <= 6'h00;
            end
        end
    end

    // ==========================================================
    // outputs
    always_comb begin
        io_rdata_o                = ctrl;
        io_rdata_o[`BIT_SEC_BUSY] = 1'b0;
    end

    assign cpu_halt_o  = (state == flash_self_prog_pkg::ST_BUSY);
    assign ready_irq_o = ctrl[`BIT_IRQ_EN] && global_irq_i && !ctrl[`BIT_STORE_EN] &&
                         !eeprom_write_pending_i &&
                         state != flash_self_prog_pkg::ST_BUSY;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lpm_override_o <= 1'b0;
            lpm_data_o     <= 8'h00;
        end else begin
            lpm_override_o <= instr_i.lpm && lpm_ok &&
                              (ctrl[`BIT_LOCK_RD] || ctrl[`BIT_SIG_RD]);
            if (instr_i.lpm && lpm_ok && ctrl[`BIT_SIG_RD]) begin
                lpm_data_o <= signature_i;
            end else if (instr_i.lpm && lpm_ok && ctrl[`BIT_LOCK_RD]) begin
                lpm_data_o <= instr_i.z_ptr[0] ? lock_bits_i : fuse_bits_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flash_cmd_o <= '0;
        end else begin
            flash_cmd_o.erase <= spm_go && ctrl[`BIT_PG_ERS];
            flash_cmd_o.write <= spm_go && ctrl[`BIT_PG_WRT];
            flash_cmd_o.load  <= spm_go && ctrl[4:1] == 4'h0;
            flash_cmd_o.clear <= (cmd_wr && pat_ok && state == flash_self_prog_pkg::ST_IDLE &&
                                  io_wdata_i[4:0] == `CMD_SEC_RE) ||
                                 (state == flash_self_prog_pkg::ST_BUSY && prog_done &&
                                  ctrl[`BIT_PG_WRT]);
            if (spm_go) begin
                flash_cmd_o.z_ptr   <= instr_i.z_ptr;
                flash_cmd_o.operand <= instr_i.operand;
            end
        end
    end

    // ==========================================================
    // checks
    property p_halt_busy;
        @(posedge clk_i) disable iff (!rst_b_i)
        $rose(cpu_halt_o) |-> $past(spm_go) && $past(ctrl[`BIT_PG_WRT] || ctrl[`BIT_PG_ERS]);
    endproperty
    a_halt_busy: assert property (p_halt_busy) else $error("halt without erase/write");

    property p_en_busy;
        @(posedge clk_i) disable iff (!rst_b_i)
        cpu_halt_o |-> ctrl[`BIT_STORE_EN] && io_rdata_o[`BIT_STORE_EN];
    endproperty
    a_en_busy: assert property (p_en_busy) else $error("store enable low while busy");

    property p_irq_block;
        @(posedge clk_i) disable iff (!rst_b_i)
        (eeprom_write_pending_i || cpu_halt_o) |-> !ready_irq_o;
    endproperty
    a_irq_block: assert property (p_irq_block) else $error("irq during programming");

    property p_irq_req;
        @(posedge clk_i) disable iff (!rst_b_i)
        (io_rdata_o[`BIT_IRQ_EN] && global_irq_i && !io_rdata_o[`BIT_STORE_EN] &&
         !eeprom_write_pending_i) |-> ready_irq_o;
    endproperty
    a_irq_req: assert property (p_irq_req) else $error("irq not raised");

    property p_busy_zero;
        @(posedge clk_i) disable iff (!rst_b_i)
        !io_rdata_o[`BIT_SEC_BUSY];
    endproperty
    a_busy_zero: assert property (p_busy_zero) else $error("busy bit set");

    property p_timeout;
        @(posedge clk_i) disable iff (!rst_b_i)
        (state == flash_self_prog_pkg::ST_IDLE && cmd_wr && pat_ok) ##1
            (!instr_i.spm && !instr_i.lpm) [*4] |=> ctrl[5:0] == 6'h00;
    endproperty
    a_timeout: assert property (p_timeout) else $error("armed bits survived window");

    property p_erase_start;
        @(posedge clk_i) disable iff (!rst_b_i)
        (spm_go && ctrl[`BIT_PG_ERS]) |=> cpu_halt_o && flash_cmd_o.erase;
    endproperty
    a_erase_start: assert property (p_erase_start) else $error("erase not started");

    property p_lock_sel;
        @(posedge clk_i) disable iff (!rst_b_i)
        (instr_i.lpm && lpm_ok && ctrl[`BIT_LOCK_RD] && !ctrl[`BIT_SIG_RD])
            |=> lpm_override_o &&
                lpm_data_o == ($past(instr_i.z_ptr[0]) ? $past(lock_bits_i) : $past(fuse_bits_i));
    endproperty
    a_lock_sel: assert property (p_lock_sel) else $error("wrong lock/fuse byte");

    property p_bad_write;
        @(posedge clk_i) disable iff (!rst_b_i)
        (state == flash_self_prog_pkg::ST_IDLE && cmd_wr && !pat_ok)
            |=> state == flash_self_prog_pkg::ST_IDLE && ctrl[5:0] == $past(ctrl[5:0]);
    endproperty
    a_bad_write: assert property (p_bad_write) else $error("invalid write accepted");

endmodule : flash_self_program_control

// >>> verification/cpu_core_model.sv
// cpu core model issuing store and load program instructions
`timescale 1ns/10ps

module cpu_core_model (
    // clock
    input  wire logic                       clk_i,
    // halt from the control block
    input  wire logic                       cpu_halt_i,
    // instruction strobes
    output flash_self_prog_pkg::instr_req_t instr_o
);
    initial instr_o = '0;

    // ==========================================================
    // one instruction, held until the next falling edge
    task automatic issue(input logic is_spm, input logic [15:0] z, input logic [15:0] opd);
        wait (cpu_halt_i === 1'b0);
        instr_o.spm     = is_spm;
        instr_o.lpm     = ~is_spm;
        instr_o.z_ptr   = z;
        instr_o.operand = opd;
        @(negedge clk_i);
        instr_o.spm     = 1'b0;
        instr_o.lpm     = 1'b0;
        // released operands no longer show the old value
        instr_o.z_ptr   = ~z;
        instr_o.operand = ~opd;
    endtask : issue
endmodule : cpu_core_model

// >>> verification/testbench.sv
// self-checking bench for the flash self-programming control block
`timescale 1ns/10ps
`include "flash_self_prog_defines.svh"

module testbench;
    // ==========================================================
    // signals
    logic                            clk_i = 1'b0;
    logic                            rst_b_i = 1'b0;
    logic                            io_wr_i = 1'b0;
    logic [5:0]                      io_addr_i = `SPCS_ADDR;
    logic [7:0]                      io_wdata_i = 8'h00;
    logic [7:0]                      io_rdata_o;
    flash_self_prog_pkg::instr_req_t instr_i;
    logic                            global_irq_i = 1'b0;
    logic                            eeprom_write_pending_i = 1'b0;
    logic                            cpu_halt_o;
    logic                            ready_irq_o;
    logic                            lpm_override_o;
    logic [7:0]                      lpm_data_o;
    flash_self_prog_pkg::flash_cmd_t flash_cmd_o;
    logic [15:0]                     last_z = 16'h0000;
    logic [15:0]                     last_op = 16'h0000;
    int                              err_total = 0;
    int                              n_tests = 0;
    int                              n_ers = 0;
    int                              n_wrt = 0;
    int                              n_ld = 0;
    int                              n_clr = 0;

    always #5 clk_i = ~clk_i;

    flash_self_program_control #(.PROG_TICKS(3)) dut_u (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
        .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .instr_i(instr_i),
        .global_irq_i(global_irq_i), .eeprom_write_pending_i(eeprom_write_pending_i),
        .cpu_halt_o(cpu_halt_o), .ready_irq_o(ready_irq_o), .lpm_override_o(lpm_override_o),
        .lpm_data_o(lpm_data_o), .lock_bits_i(8'ha5), .fuse_bits_i(8'h3c),
        .signature_i(8'h96), .flash_cmd_o(flash_cmd_o));

    cpu_core_model cpu_u (.clk_i(clk_i), .cpu_halt_i(cpu_halt_o), .instr_o(instr_i));

    // ==========================================================
    // flash request monitor
    always @(posedge clk_i) begin
        if (flash_cmd_o.erase === 1'b1) n_ers++;
        if (flash_cmd_o.write === 1'b1) n_wrt++;
        if (flash_cmd_o.clear === 1'b1) n_clr++;
        if (flash_cmd_o.load === 1'b1) begin
            n_ld++;
            last_op <= flash_cmd_o.operand;
        end
        if ((flash_cmd_o.erase | flash_cmd_o.write) === 1'b1) last_z <= flash_cmd_o.z_ptr;
    end

    // ==========================================================
    // tasks
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] d);
        io_wdata_i = d;
        io_wr_i    = 1'b1;
        @(negedge clk_i);
        io_wr_i    = 1'b0;
        // one idle cycle so back-to-back writes never retoggle the strobe
        @(negedge clk_i);
    endtask : wr

    task automatic cmd(input logic [7:0] d);
        int k;
        k = 0;
        global_irq_i = 1'b0;
        while (io_rdata_o[0] !== 1'b0 && k < 1000) begin
            @(negedge clk_i);
            k++;
        end
        chk("idle before cmd", 16'h0000, 16'(io_rdata_o[0]));
        wr(d);
    endtask : cmd

    task automatic prog(input logic [7:0] d, input logic [15:0] z);
        int k;
        k = 0;
        cmd(d);
        cpu_u.issue(1'b1, z, 16'hbeef);
        while (cpu_halt_o !== 1'b1 && k < 3) begin
            @(negedge clk_i);
            k++;
        end
        chk("bits while busy", 16'(d), 16'(io_rdata_o));
        chk("irq while busy", 16'h0000, 16'(ready_irq_o));
        k = 0;
        while (cpu_halt_o === 1'b1 && k < 1000) begin
            @(negedge clk_i);
            k++;
        end
        chk("halt cycles", 16'd300, 16'(k));
        chk("bits after op", 16'(d & 8'h80), 16'(io_rdata_o));
        global_irq_i = 1'b1;
        #1;
        chk("ready irq", 16'h0001, 16'(ready_irq_o));
        $display("test program %h done", d);
    endtask : prog

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // ==========================================================
    // watchdog
    initial begin
        #100000;
        err_total++;
        print_verdict();
    end

    // ==========================================================
    // tests
    initial begin
        logic [7:0] tmo [2];
        tmo = '{8'h83, 8'h85};
        repeat (3) @(negedge clk_i);
        rst_b_i = 1'b1;
        @(negedge clk_i);
        chk("reset value", 16'h0000, 16'(io_rdata_o));
        io_addr_i = 6'h3f;
        wr(8'h81);
        io_addr_i = `SPCS_ADDR;
        chk("other address", 16'h0000, 16'(io_rdata_o));
        wr(8'h9f);
        chk("bad pattern", 16'h0080, 16'(io_rdata_o));
        wr(8'h40);
        chk("busy bit", 16'h0000, 16'(io_rdata_o));
        wr(8'h80);
        global_irq_i = 1'b1;
        #1;
        chk("irq enable", 16'h0001, 16'(ready_irq_o));
        eeprom_write_pending_i = 1'b1;
        #1;
        chk("irq eeprom", 16'h0000, 16'(ready_irq_o));
        eeprom_write_pending_i = 1'b0;
        $display("test register done");
        prog(8'h83, 16'h1240);
        chk("erase count", 16'd1, 16'(n_ers));
        chk("erase page", 16'h1240, last_z);
        prog(8'h85, 16'h1280);
        chk("write count", 16'd1, 16'(n_wrt));
        chk("write page", 16'h1280, last_z);
        foreach (tmo[i]) begin
            wr(tmo[i]);
            repeat (2) @(negedge clk_i);
            chk("armed", 16'(tmo[i]), 16'(io_rdata_o));
            @(negedge clk_i);
            chk("expired", 16'h0080, 16'(io_rdata_o));
            cpu_u.issue(1'b1, 16'h1280, 16'h0000);
            @(negedge clk_i);
            chk("late store", 16'd2, 16'(n_ers + n_wrt));
        end
        $display("test timeout done");
        cmd(8'h01);
        cpu_u.issue(1'b1, 16'h0042, 16'h5a3c);
        repeat (2) @(negedge clk_i);
        chk("load count", 16'd1, 16'(n_ld));
        chk("load data", 16'h5a3c, last_op);
        chk("store done", 16'h0000, 16'(io_rdata_o));
        for (int i = 0; i < 2; i++) begin
            cmd(8'h09);
            cpu_u.issue(1'b0, 16'(i), 16'h0000);
            chk("override", 16'h0001, 16'(lpm_override_o));
            @(negedge clk_i);
            chk("lock fuse", (i == 1) ? 16'h00a5 : 16'h003c, 16'(lpm_data_o));
        end
        cmd(8'h21);
        cpu_u.issue(1'b0, 16'h0000, 16'h0000);
        @(negedge clk_i);
        chk("signature", 16'h0096, 16'(lpm_data_o));
        cmd(8'h21);
        cpu_u.issue(1'b1, 16'h1240, 16'h1111);
        repeat (6) @(negedge clk_i);
        chk("sig store", 16'd3, 16'(n_ers + n_wrt + n_ld + cpu_halt_o));
        $display("test read done");
        cmd(8'h11);
        repeat (2) @(negedge clk_i);
        chk("buffer clear", 16'd2, 16'(n_clr));
        chk("section busy", 16'h0000, 16'(io_rdata_o[6]));
        $display("test section done");
        print_verdict();
    end
endmodule : testbench
